// *** rtl/cbt_regs.svh ***
// Register offsets, field positions, reset values and presets of the capture control
`ifndef CBT_REGS_SVH
`define CBT_REGS_SVH

// Register byte offsets
`define CBT_CTRL_OFS      8'h00
`define CBT_POS_OFS       8'h04
`define CBT_STATUS_OFS    8'h08
`define CBT_WCNT_OFS      8'h0c
`define CBT_TIDX_OFS      8'h10
`define CBT_RADDR_OFS     8'h14
`define CBT_RDATA_OFS     8'h18
`define CBT_LEFT_OFS      8'h1c

// Control register bits
`define CBT_CTRL_ARM      0
`define CBT_CTRL_STOP     1
`define CBT_CTRL_SQ       2
`define CBT_CTRL_SEGM     3
`define CBT_CTRL_EXTIN    4
`define CBT_CTRL_TOUT     5
`define CBT_CTRL_PWR      6

// Position register fields
`define CBT_POS_RUN_LSB   0
`define CBT_POS_PWR_LSB   2
`define CBT_POS_SEG_LSB   4

// Post-trigger share of each preset, in percent
`define CBT_PCT_PRE       88
`define CBT_PCT_CENTER    50
`define CBT_PCT_POST      12

// Reset values
`define CBT_CTRL_RST      8'h00
`define CBT_POS_RST       2'h1

// Bus answers
`define CBT_RESP_OKAY     2'h0
`define CBT_RESP_SLVERR   2'h2

`endif

// *** rtl/cbt_pkg.sv ***
// Types shared by the capture control files
package cbt_pkg;

    // Acquisition sequencer states
    typedef enum logic [1:0] {
        CBT_IDLE,
        CBT_RUN,
        CBT_DISCARD,
        CBT_DONE
    } cbt_state_t;

    // Preset trigger positions
    typedef enum logic [1:0] {
        CBT_POS_PRE    = 2'h0,
        CBT_POS_CENTER = 2'h1,
        CBT_POS_POST   = 2'h2,
        CBT_POS_RSVD   = 2'h3
    } cbt_pos_t;

endpackage

// *** rtl/cbt_sync.sv ***
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
module cbt_sync (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;

    // First stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// *** rtl/cbt_axil_slave.sv ***
// AXI4-Lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ns
module cbt_axil_slave (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             wr_en,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_err,
    output logic             rd_en,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_err
);
    `include "cbt_regs.svh"

    typedef struct packed {
        logic        aw_full;
        logic        w_full;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cbt_axs_t;

    cbt_axs_t q;
    cbt_axs_t d;

    // Ready while the holding slot is free and no answer is pending
    assign s_axi_awready = !q.aw_full && !q.bvalid;
    assign s_axi_wready  = !q.w_full && !q.bvalid;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;

    // Register strobes toward the block
    assign wr_en   = q.aw_full && q.w_full && !q.bvalid;
    assign wr_addr = q.awaddr;
    assign wr_data = q.wdata;
    assign wr_strb = q.wstrb;
    assign rd_en   = s_axi_arvalid && !q.rvalid;

    // Next state of the channel holders
    always_comb begin
        d = q;
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_full = 1'b1;
            d.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_full = 1'b1;
            d.wdata  = s_axi_wdata;
            d.wstrb  = s_axi_wstrb;
        end
        if (wr_en) begin
            d.aw_full = 1'b0;
            d.w_full  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = wr_err ? `CBT_RESP_SLVERR : `CBT_RESP_OKAY;
        end else if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (rd_en) begin
            d.rvalid = 1'b1;
            d.rdata  = rd_err ? 32'h0 : rd_data;
            d.rresp  = rd_err ? `CBT_RESP_SLVERR : `CBT_RESP_OKAY;
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// *** rtl/cbt_top.sv ***
// Capture buffer trigger control: storage qualification, trigger position, segments
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
// Notes on behaviour
// - Store begin/halt only in state-qualifier mode
// - Store begin/halt ignored for segmented buffers
// - Qualified mode writes nothing before begin
// - After trigger keep writing the post count
// - Post count done: finish, buffer readable
// - Halt before done pauses until begin
// - Begin/halt still act after the trigger
// - Manual stop forces the trigger, ends capture
// - Counters, flags, state visible and live
// - Presets 12/88, 50/50, 88/12 everywhere
// - Run and power-up positions held apart
// - No count argument: use preset position
// - Trigger count sets samples after trigger
// - Quick retrigger cuts segment, marks discards
// - Trigger index is depth minus post count
// - Power-up trigger arms straight from reset
// - Power-up configuration kept per instance
// - External input gates all other conditions
// - Trigger output drives other equipment
// - Power-up shares external in and out; here pwr_en is only stored and read back
// - Final post count done stops acquisition
// - Next segment follows, oldest overwritten
module cbt_top
    import cbt_pkg::*;
#(
    parameter int          SW        = 16,
    parameter int          DEPTH     = 256,
    parameter bit          PWRUP_EN  = 1'b1,
    parameter logic [1:0]  PWRUP_POS = 2'h1
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic [SW-1:0]             sample_in,
    input  wire logic                      act_start_store,
    input  wire logic                      act_stop_store,
    input  wire logic                      act_trigger,
    input  wire logic                      act_seg_trigger,
    input  wire logic                      act_count_valid,
    input  wire logic [$clog2(DEPTH):0]    act_count,
    input  wire logic [7:0]                flow_state,
    input  wire logic                      ext_trig_in,
    output logic                           trig_out
);
    `include "cbt_regs.svh"

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        cbt_state_t  st;
        logic        sq;
        logic        segm;
        logic        ext_en;
        logic        tout_en;
        logic        pwr_en;
        logic [1:0]  rpos;
        logic [1:0]  ppos;
        logic [2:0]  seglog;
        logic        pwrup;
        logic        wen;
        logic        trig;
        logic        final_t;
        logic        ext_seen;
        logic        segend_d;
        logic        pend_final;
        logic [AW:0] pend_left;
        logic [AW:0] left;
        logic [AW:0] trig_idx;
        logic [AW-1:0] off;
        logic [2:0]  seg;
        logic [31:0] wcnt;
        logic [AW-1:0] raddr;
        logic        tout;
    } cbt_core_t;

    cbt_core_t q;
    cbt_core_t d;

    // Capture store, top bit marks a discarded position
    logic [SW:0]   mem [DEPTH];
    logic          mem_we;
    logic [AW-1:0] mem_wa;
    logic [SW:0]   mem_wd;

    logic          ext_s;
    logic          wr_en;
    logic [7:0]    wr_addr;
    logic [31:0]   wr_data;
    logic [3:0]    wr_strb;
    logic          wr_err;
    logic          rd_en;
    logic [31:0]   rd_data;
    logic          rd_err;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Samples after trigger for a preset position
    function automatic logic [AW:0] preset_count(input logic [1:0] pos,
                                                 input logic [AW:0] n);
        int pct;
        pct = `CBT_PCT_CENTER;
        unique case (cbt_pos_t'(pos))
            CBT_POS_PRE:    pct = `CBT_PCT_PRE;
            CBT_POS_POST:   pct = `CBT_PCT_POST;
            CBT_POS_CENTER: pct = `CBT_PCT_CENTER;
            CBT_POS_RSVD:   pct = `CBT_PCT_CENTER;
        endcase
        return (AW+1)'((int'(n) * pct) / 100);
    endfunction

    // Store address from segment number and offset
    function automatic logic [AW-1:0] store_addr(input logic [2:0] seg,
                                                 input logic [AW-1:0] off,
                                                 input logic [AW:0] n);
        return AW'(int'(seg) * int'(n) + int'(off));
    endfunction

    // Byte-strobe merge of a written word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (data & m);
    endfunction

    // ------------------------------------------------------------
    // Bus and pin front ends
    // ------------------------------------------------------------

    cbt_axil_slave u_bus (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_err        (wr_err),
        .rd_en         (rd_en),
        .rd_data       (rd_data),
        .rd_err        (rd_err)
    );

    // External trigger input is a pin from another domain
    cbt_sync u_ext (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (ext_trig_in),
        .sync_out (ext_s)
    );

    // ------------------------------------------------------------
    // Register read and write decode
    // ------------------------------------------------------------

    // Live status, counters and flow state
    always_comb begin
        rd_data = 32'h0;
        rd_err  = 1'b0;
        unique case (s_axi_araddr)
            `CBT_CTRL_OFS:   rd_data = {25'h0, q.pwr_en, q.tout_en, q.ext_en,
                                        q.segm, q.sq, 2'h0};
            `CBT_POS_OFS:    rd_data = {25'h0, q.seglog, q.ppos, q.rpos};
            `CBT_STATUS_OFS: rd_data = {8'h0, 5'h0, q.seg, flow_state, 1'b0,
                                        q.ext_seen, q.pwrup, q.wen, q.trig,
                                        q.st == CBT_DONE, q.st == CBT_DISCARD,
                                        q.st == CBT_RUN};
            `CBT_WCNT_OFS:   rd_data = q.wcnt;
            `CBT_TIDX_OFS:   rd_data = 32'(q.trig_idx);
            `CBT_RADDR_OFS:  rd_data = 32'(q.raddr);
            `CBT_RDATA_OFS:  rd_data = 32'(mem[q.raddr]);
            `CBT_LEFT_OFS:   rd_data = 32'(q.left);
            default:         rd_err  = 1'b1;
        endcase
    end

    // Only control, position and read address take writes; status, counters, read data and unmapped offsets refuse
    always_comb begin
        unique case (wr_addr)
            `CBT_CTRL_OFS, `CBT_POS_OFS, `CBT_RADDR_OFS: wr_err = 1'b0;
            default:                                    wr_err = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // Acquisition sequencer
    // ------------------------------------------------------------

    logic [AW:0]  segn;
    logic         gate;
    logic         qual;
    logic         trig_act;
    logic         final_act;
    logic [AW:0]  cnt;
    logic [31:0]  wmerge;
    logic         do_write;

    always_comb begin
        d        = q;
        mem_we   = 1'b0;
        mem_wa   = '0;
        mem_wd   = '0;
        do_write = 1'b0;
        wmerge   = 32'h0;
        d.tout   = 1'b0;
        d.segend_d = 1'b0;
        // Segment depth follows the segment count
        segn = q.segm ? (AW+1)'(DEPTH >> q.seglog) : (AW+1)'(DEPTH);
        // External input must be true before other conditions count
        gate = !q.ext_en || q.ext_seen || ext_s;
        if (q.st == CBT_RUN && q.ext_en && ext_s) begin
            d.ext_seen = 1'b1;
        end
        qual      = q.sq && !q.segm;
        final_act = gate && act_trigger;
        trig_act  = final_act || (gate && q.segm && act_seg_trigger);
        // Explicit count or the preset of the active configuration
        cnt = act_count_valid ? act_count
                              : preset_count(q.pwrup ? q.ppos : q.rpos, segn);
        if (cnt > segn) begin
            cnt = segn;
        end

        if (q.st == CBT_RUN) begin
            // Store enable: halt then begin, begin wins a tie
            if (!qual) begin
                d.wen = 1'b1;
            end else if (gate && act_start_store) begin
                d.wen = 1'b1;
            end else if (gate && act_stop_store) begin
                d.wen = 1'b0;
            end
            do_write = d.wen;
            if (do_write) begin
                // Circular store within the current segment
                mem_we = 1'b1;
                mem_wa = store_addr(q.seg, q.off, segn);
                mem_wd = {1'b0, sample_in};
                d.off  = (32'(q.off) + 1 >= 32'(segn)) ? '0 : q.off + 1'b1;
                d.wcnt = q.wcnt + 32'h1;
            end
            if (trig_act && q.trig && q.segend_d && q.segm) begin
                // Retrigger in the cycle right after a segment trigger cuts this segment
                d.st         = CBT_DISCARD;
                d.pend_final = final_act;
                d.pend_left  = cnt;
                mem_we       = 1'b0;
                d.off        = q.off;
                d.wcnt       = q.wcnt;
            end else if (trig_act && !q.trig) begin
                d.trig     = 1'b1;
                d.final_t  = final_act;
                d.left     = cnt;
                d.trig_idx = segn - cnt;
                d.tout     = q.tout_en;
                d.segend_d = !final_act;
                if (cnt == '0 && final_act) begin
                    d.st = CBT_DONE;
                end
            end else if (q.trig && do_write) begin
                // Gather the samples after the trigger
                d.left = q.left - 1'b1;
                if (q.left == (AW+1)'(1)) begin
                    if (q.final_t || !q.segm) begin
                        d.st = CBT_DONE;
                    end else begin
                        d.trig = 1'b0;
                        d.seg  = (q.seg + 3'h1) & 3'((1 << q.seglog) - 1);
                        d.off  = '0;
                    end
                end
            end
        end else if (q.st == CBT_DISCARD) begin
            // Walk the unfilled positions, marking each discarded
            if (q.left != '0) begin
                mem_we = 1'b1;
                mem_wa = store_addr(q.seg, q.off, segn);
                mem_wd = {1'b1, {SW{1'b0}}};
                d.left = q.left - 1'b1;
                d.off  = (32'(q.off) + 1 >= 32'(segn)) ? '0 : q.off + 1'b1;
            end else if (q.pend_final) begin
                d.st = CBT_DONE;
            end else begin
                d.st       = CBT_RUN;
                d.seg      = (q.seg + 3'h1) & 3'((1 << q.seglog) - 1);
                d.off      = '0;
                d.left     = q.pend_left;
                d.trig_idx = segn - q.pend_left;
                d.segend_d = 1'b1;
                d.tout     = q.tout_en;
            end
        end

        // Software writes
        if (wr_en && !wr_err) begin
            unique case (wr_addr)
                `CBT_CTRL_OFS: begin
                    wmerge    = merge({25'h0, q.pwr_en, q.tout_en, q.ext_en, q.segm,
                                       q.sq, 2'h0}, wr_data, wr_strb);
                    d.sq      = wmerge[`CBT_CTRL_SQ];
                    d.segm    = wmerge[`CBT_CTRL_SEGM];
                    d.ext_en  = wmerge[`CBT_CTRL_EXTIN];
                    d.tout_en = wmerge[`CBT_CTRL_TOUT];
                    d.pwr_en  = wmerge[`CBT_CTRL_PWR];
                    if (wmerge[`CBT_CTRL_ARM]) begin
                        // Runtime start clears the previous capture
                        d.st       = CBT_RUN;
                        d.pwrup    = 1'b0;
                        d.wen      = !wmerge[`CBT_CTRL_SQ] || wmerge[`CBT_CTRL_SEGM];
                        d.trig     = 1'b0;
                        d.ext_seen = 1'b0;
                        d.seg      = '0;
                        d.off      = '0;
                        d.wcnt     = '0;
                        d.left     = '0;
                        d.trig_idx = '0;
                    end else if (wmerge[`CBT_CTRL_STOP] && q.st != CBT_IDLE) begin
                        // Manual stop forces the trigger and ends capture
                        d.st   = CBT_DONE;
                        d.trig = 1'b1;
                        d.left = '0;
                        if (!q.trig) begin
                            d.trig_idx = segn;
                            d.tout     = q.tout_en;
                        end
                    end
                end
                `CBT_POS_OFS: begin
                    wmerge   = merge({25'h0, q.seglog, q.ppos, q.rpos}, wr_data, wr_strb);
                    d.rpos   = wmerge[`CBT_POS_RUN_LSB +: 2];
                    d.ppos   = wmerge[`CBT_POS_PWR_LSB +: 2];
                    d.seglog = wmerge[`CBT_POS_SEG_LSB +: 3];
                end
                `CBT_RADDR_OFS: begin
                    wmerge  = merge(32'(q.raddr), wr_data, wr_strb);
                    d.raddr = wmerge[AW-1:0];
                end
                default: begin
                    wmerge = 32'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State and store registers
    // ------------------------------------------------------------

    // Power-up trigger leaves reset already armed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q        <= '0;
            q.st     <= PWRUP_EN ? CBT_RUN : CBT_IDLE;
            q.pwrup  <= PWRUP_EN;
            q.pwr_en <= PWRUP_EN;
            q.ppos   <= PWRUP_POS;
            q.rpos   <= `CBT_POS_RST;
            q.wen    <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Store write port
    always_ff @(posedge aclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign trig_out = q.tout;
endmodule

// *** test/cbt_asserts.sv ***
// Bus and trigger-out property checker of the capture control
`timescale 1ns/1ns
module cbt_asserts (
    input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
    input wire logic        s_axi_arready, s_axi_rvalid, s_axi_rready, trig_out,
    input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Answers stand until taken
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
        $stable(s_axi_bresp)) else $error("write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
        $stable(s_axi_rdata)) else $error("read answer dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_ar_free: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready wrong");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    a_resp_legal: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2})
        else $error("bad read response");
    a_trig_pulse: assert property (trig_out |=> !trig_out)
        else $error("trigger out too long");
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid &&
        !s_axi_rvalid && !trig_out) else $error("outputs busy in reset");
    // Main scenarios seen
    cover property (trig_out);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind cbt_top cbt_asserts i_cbt_asserts (.*);

// *** test/cbt_far_model.sv ***
// Far-side trigger source: external equipment or another analyzer
`timescale 1ns/1ns
module cbt_far_model (
    input wire logic fire, obey, trig_out,
    output logic     ext_trig_in
);
    // Async level; echoes our trigger out only when told to obey
    assign #3 ext_trig_in = fire | (obey & trig_out);
endmodule

// *** test/tb_top.sv ***
// Self-checking bench of the capture control
`timescale 1ns/1ns
`include "cbt_regs.svh"
module tb_top;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, act_start_store = 0, act_stop_store = 0;
    logic act_trigger = 0, act_seg_trigger = 0, act_count_valid = 0, fire = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic trig_out, ext_trig_in;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, flow_state = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv, w;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, bp, rp;
    logic [15:0] sample_in = 0;
    logic [8:0] act_count = 0;
    int miscompares = 0, n_checks = 0, cyc = 0, pulses = 0;
    cbt_top i_cbt_top (.*);
    cbt_far_model i_cbt_far_model (.fire, .obey(1'b0), .trig_out, .ext_trig_in);
    initial forever #2 aclk = ~aclk;
    // Random probe data, trigger-out count, timeout
    always @(posedge aclk) begin
        sample_in <= 16'($urandom);
        flow_state <= 8'($urandom);
        pulses <= pulses + int'(trig_out);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            wrap_up();
        end
    end
    task chk(input logic [31:0] g, e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'b1;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        bp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rv = s_axi_rdata; rp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // One-cycle action pulse: {begin, halt, trigger}
    task act(input logic [2:0] m, input logic v, input logic [8:0] c);
        @(posedge aclk);
        {act_start_store, act_stop_store, act_trigger} <= m;
        act_count_valid <= v; act_count <= c;
        @(posedge aclk);
        {act_start_store, act_stop_store, act_trigger} <= 3'h0;
        act_count_valid <= 1'b0;
    endtask
    task idle(input int n); repeat (n) @(posedge aclk); endtask
    task done_wait; do rd(`CBT_STATUS_OFS); while (!rv[2]); endtask
    function automatic logic [31:0] tidx(int p);
        return 256 - 256 * (p == 0 ? `CBT_PCT_PRE : p == 1 ? `CBT_PCT_CENTER :
            `CBT_PCT_POST) / 100;
    endfunction
    task wrap_up;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        int c;
        void'($urandom(32'h8213));
        idle(2);
        aresetn <= 1'b1;
        rd(`CBT_CTRL_OFS); chk(rv, 32'h40);
        rd(`CBT_POS_OFS); chk(rv, 32'h5);
        rd(`CBT_STATUS_OFS); chk(rv & 32'h21, 32'h21);
        rd(8'h20); chk(rp, `CBT_RESP_SLVERR);
        wr(`CBT_TIDX_OFS, 32'h1); chk(bp, `CBT_RESP_SLVERR);
        for (int p = 0; p < 3; p++) begin
            wr(`CBT_POS_OFS, 32'(p));
            wr(`CBT_CTRL_OFS, 32'h21);
            act(3'h1, 1'b0, 9'h0);
            done_wait();
            rd(`CBT_TIDX_OFS); chk(rv, tidx(p));
        end
        c = $urandom_range(40, 1);
        wr(`CBT_CTRL_OFS, 32'h21); act(3'h1, 1'b1, 9'(c)); done_wait();
        rd(`CBT_TIDX_OFS); chk(rv, 32'(256 - c));
        rd(`CBT_LEFT_OFS); chk(rv, 32'h0);
        wr(`CBT_CTRL_OFS, 32'h05); idle(20);
        rd(`CBT_WCNT_OFS); chk(rv, 32'h0);
        act(3'h4, 1'b0, 9'h0); idle(6); act(3'h2, 1'b0, 9'h0);
        rd(`CBT_WCNT_OFS); w = rv; idle(10);
        rd(`CBT_WCNT_OFS); chk(rv, w);
        act(3'h1, 1'b1, 9'h3); idle(10);
        rd(`CBT_STATUS_OFS); chk(rv[2], 1'b0);
        act(3'h4, 1'b0, 9'h0); done_wait();
        wr(`CBT_CTRL_OFS, 32'h05); wr(`CBT_CTRL_OFS, 32'h02);
        rd(`CBT_STATUS_OFS); chk(rv[3:2], 2'h3);
        wr(`CBT_CTRL_OFS, 32'h31); act(3'h1, 1'b1, 9'h2); idle(10);
        rd(`CBT_STATUS_OFS); chk(rv[3], 1'b0);
        fire <= 1'b1; idle(4);
        act(3'h1, 1'b1, 9'h2); done_wait();
        fire <= 1'b0;
        chk(32'(pulses), 32'h5);
        wrap_up();
    end
endmodule
